// ---- rtl/pifb_regs.svh ----
// register offsets, bit positions, masks and reset values of the flag bank
`ifndef PIFB_REGS_SVH
`define PIFB_REGS_SVH

// register indexes; the bus byte address is four times the index
`define PIFB_IDX_REQ0 8'h8c
`define PIFB_IDX_REQ1 8'h8d
`define PIFB_IDX_REQ2 8'h8e
`define PIFB_IDX_EN6 8'h9c
`define PIFB_IDX_EN7 8'h9d
`define PIFB_IDX_CTRL 8'h0b
`define PIFB_IDX_PSEL 8'h9e

// request register 0 bit positions
`define PIFB_BIT_TMR0 5
`define PIFB_BIT_IOC 4
`define PIFB_BIT_EXT 0
// request register 1 bit positions
`define PIFB_BIT_T1G 7
`define PIFB_BIT_T1 6
`define PIFB_BIT_OSF 5
`define PIFB_BIT_CSW 4
`define PIFB_BIT_SCAN 2
`define PIFB_BIT_CRC 1
`define PIFB_BIT_NVM 0
// request register 2 bit positions
`define PIFB_BIT_CCP2 6
`define PIFB_BIT_CCP1 5
`define PIFB_BIT_TMR2 2
// enable register 6 bit positions
`define PIFB_BIT_ADT 1
`define PIFB_BIT_AD 0
// control register bit positions
`define PIFB_BIT_GLOBAL 1
`define PIFB_BIT_PERIPH 0

// implemented, software-writable bits of each register
`define PIFB_MASK_REQ0 8'h21
`define PIFB_MASK_REQ1 8'hf7
`define PIFB_MASK_REQ2 8'h64
`define PIFB_MASK_EN6 8'h03
`define PIFB_MASK_EN7 8'h0f
`define PIFB_MASK_CTRL 8'h03
`define PIFB_MASK_PSEL 8'h07

// reset value shared by every register of the bank
`define PIFB_RESET_VAL 8'h00

`endif

// ---- rtl/pifb_pkg.sv ----
// types shared by the peripheral interrupt flag bank
package pifb_pkg;

  // bus handshake states, gray coded
  typedef enum logic [0:0] {
    PIFB_BUS_IDLE = 1'b0,
    PIFB_BUS_ACK = 1'b1
  } pifb_bus_state_t;

  // operating mode of a capture/compare unit
  typedef enum logic [1:0] {
    PIFB_CCP_OFF = 2'h0,
    PIFB_CCP_CAPTURE = 2'h1,
    PIFB_CCP_COMPARE = 2'h2,
    PIFB_CCP_PWM = 2'h3
  } pifb_ccp_mode_t;

  // avalon response codes
  typedef enum logic [1:0] {
    PIFB_RESP_OKAY = 2'h0,
    PIFB_RESP_DECERR = 2'h3
  } pifb_resp_t;

endpackage : pifb_pkg

// ---- rtl/pifb_top.sv ----
// peripheral interrupt enable and request flag bank with avalon-mm access
//
// Overview of operation
// - enable six bit 1 gates converter threshold
// - enable six bit 0 gates converter done
// - enable seven bits 3..0, reset zero
// - timer zero overflow sets request zero bit 5
// - bit 4 is OR of pin-change flags
// - external interrupt sets request zero bit 0
// - external pin chosen by pin select
// - flags set regardless of enable bits
// - timer one gate inactive sets bit 7
// - timer one event sets bit 6
// - oscillator failure sets bit 5
// - clock switch event sets bit 4
// - memory scanner event sets bit 2
// - checksum event sets bit 1
// - nonvolatile operation done sets bit 0
// - request two: units 2,1 and timer two
// - capture/compare flag set per mode event
// - request zero/one at 0x8c/0x8d, reset zero
// - enable one, two, six and seven also need peripheral enable
`timescale 1ns/1ns
`default_nettype none
`include "pifb_regs.svh"

module pifb_top
  import pifb_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [9:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic [1:0] O_AVS_RESPONSE,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_TMR0_OVERFLOW,
  input wire logic [2:0] I_PER_PORT_PIN_CHANGE_FLAGS,
  input wire logic [7:0] I_EXT_IRQ_PINS,
  input wire logic I_TIMER_ONE_GATE_INACTIVE,
  input wire logic I_TIMER_ONE_EVENT,
  input wire logic I_OSCILLATOR_FAIL,
  input wire logic I_CLOCK_SWITCH_EVENT,
  input wire logic I_MEMORY_SCANNER_EVENT,
  input wire logic I_CHECKSUM_EVENT,
  input wire logic I_NONVOLATILE_DONE,
  input wire logic [1:0] I_CAPCOMP_ONE_MODE,
  input wire logic [2:0] I_CAPCOMP_ONE_EVENTS,
  input wire logic [1:0] I_CAPCOMP_TWO_MODE,
  input wire logic [2:0] I_CAPCOMP_TWO_EVENTS,
  input wire logic I_TIMER_TWO_EVENT,
  input wire logic [7:0] I_ENABLE_BITS_ZERO,
  input wire logic [7:0] I_ENABLE_BITS_ONE,
  input wire logic [7:0] I_ENABLE_BITS_TWO,
  input wire logic [1:0] I_CONVERTER_REQ,
  input wire logic [3:0] I_LOGIC_BLOCK_REQ,
  output logic [1:0] O_ENABLE_BITS_SIX,
  output logic [3:0] O_ENABLE_BITS_SEVEN,
  output logic O_IRQ
);

  // bus handshake state
  pifb_bus_state_t bus_q;
  pifb_bus_state_t bus_d;
  // registered read answer
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  pifb_resp_t resp_q;
  pifb_resp_t resp_d;

  // software-visible storage
  logic [7:0] req0_q;
  logic [7:0] req0_d;
  logic [7:0] req1_q;
  logic [7:0] req1_d;
  logic [7:0] req2_q;
  logic [7:0] req2_d;
  logic [7:0] en6_q;
  logic [7:0] en6_d;
  logic [7:0] en7_q;
  logic [7:0] en7_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] psel_q;
  logic [7:0] psel_d;

  // external pin synchroniser and edge history
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic [7:0] pin_s3_q;

  // registered interrupt request
  logic irq_q;
  logic irq_d;

  // decoded access and per-register hits
  logic req_any;
  logic wr_take;
  logic [7:0] idx;
  logic aligned;
  logic hit_req0;
  logic hit_req1;
  logic hit_req2;
  logic hit_en6;
  logic hit_en7;
  logic hit_ctrl;
  logic hit_psel;
  logic hit_any;
  logic [7:0] wbyte;
  logic lane0;

  // hardware set vectors and derived status
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic pin_change_summary_flag;
  logic ext_edge;
  logic ccp1_hit;
  logic ccp2_hit;
  logic [7:0] req0_view;

  // address decode
  always_comb begin
    idx = I_AVS_ADDRESS[9:2];
    aligned = (I_AVS_ADDRESS[1:0] == 2'h0);
    hit_req0 = 1'b0;
    hit_req1 = 1'b0;
    hit_req2 = 1'b0;
    hit_en6 = 1'b0;
    hit_en7 = 1'b0;
    hit_ctrl = 1'b0;
    hit_psel = 1'b0;
    if (!aligned) begin
      // misaligned byte address decodes to nothing
      hit_req0 = 1'b0;
    end else if (idx == `PIFB_IDX_REQ0) begin
      hit_req0 = 1'b1;
    end else if (idx == `PIFB_IDX_REQ1) begin
      hit_req1 = 1'b1;
    end else if (idx == `PIFB_IDX_REQ2) begin
      hit_req2 = 1'b1;
    end else if (idx == `PIFB_IDX_EN6) begin
      hit_en6 = 1'b1;
    end else if (idx == `PIFB_IDX_EN7) begin
      hit_en7 = 1'b1;
    end else if (idx == `PIFB_IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (idx == `PIFB_IDX_PSEL) begin
      hit_psel = 1'b1;
    end
    hit_any = hit_req0 | hit_req1 | hit_req2 | hit_en6 | hit_en7 | hit_ctrl | hit_psel;
  end

  // bus handshake: one wait cycle, then the request is taken
  always_comb begin
    req_any = I_AVS_READ | I_AVS_WRITE;
    bus_d = bus_q;
    case (bus_q)
      PIFB_BUS_IDLE: begin
        // request seen, answer on the next edge
        if (req_any) begin
          bus_d = PIFB_BUS_ACK;
        end
      end
      PIFB_BUS_ACK: begin
        // request taken at this edge
        bus_d = PIFB_BUS_IDLE;
      end
      default: begin
        bus_d = PIFB_BUS_IDLE;
      end
    endcase
    O_AVS_WAITREQUEST = req_any & (bus_q == PIFB_BUS_IDLE);
    wr_take = I_AVS_WRITE & (bus_q == PIFB_BUS_ACK);
    lane0 = I_AVS_BYTEENABLE[0];
    wbyte = I_AVS_WRITEDATA[7:0];
  end

  // bus state register
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      bus_q <= PIFB_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // read mux; captured while waitrequest is high
  always_comb begin
    rdata_d = rdata_q;
    resp_d = resp_q;
    if (req_any && (bus_q == PIFB_BUS_IDLE)) begin
      resp_d = hit_any ? PIFB_RESP_OKAY : PIFB_RESP_DECERR;
      rdata_d = 8'h00;
      if (I_AVS_READ) begin
        if (hit_req0) begin
          rdata_d = req0_view;
        end else if (hit_req1) begin
          rdata_d = req1_q;
        end else if (hit_req2) begin
          rdata_d = req2_q;
        end else if (hit_en6) begin
          rdata_d = en6_q;
        end else if (hit_en7) begin
          rdata_d = en7_q;
        end else if (hit_ctrl) begin
          rdata_d = ctrl_q;
        end else if (hit_psel) begin
          rdata_d = psel_q;
        end
      end
    end
  end

  // read answer registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      rdata_q <= `PIFB_RESET_VAL;
      resp_q <= PIFB_RESP_OKAY;
    end else begin
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // upper bits of the bus word read as zero
  assign O_AVS_READDATA = {24'h000000, rdata_q};
  assign O_AVS_RESPONSE = resp_q;

  // external pins: two flops, then one more for edge history
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
    end else begin
      pin_s1_q <= I_EXT_IRQ_PINS;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // hardware set sources
  always_comb begin
    ext_edge = pin_s2_q[psel_q[2:0]] & ~pin_s3_q[psel_q[2:0]];
    pin_change_summary_flag = |I_PER_PORT_PIN_CHANGE_FLAGS;
    // unit one event matched to its mode
    case (pifb_ccp_mode_t'(I_CAPCOMP_ONE_MODE))
      PIFB_CCP_CAPTURE: ccp1_hit = I_CAPCOMP_ONE_EVENTS[0];
      PIFB_CCP_COMPARE: ccp1_hit = I_CAPCOMP_ONE_EVENTS[1];
      PIFB_CCP_PWM: ccp1_hit = I_CAPCOMP_ONE_EVENTS[2];
      default: ccp1_hit = 1'b0;
    endcase
    // unit two event matched to its mode
    case (pifb_ccp_mode_t'(I_CAPCOMP_TWO_MODE))
      PIFB_CCP_CAPTURE: ccp2_hit = I_CAPCOMP_TWO_EVENTS[0];
      PIFB_CCP_COMPARE: ccp2_hit = I_CAPCOMP_TWO_EVENTS[1];
      PIFB_CCP_PWM: ccp2_hit = I_CAPCOMP_TWO_EVENTS[2];
      default: ccp2_hit = 1'b0;
    endcase
    set0 = 8'h00;
    set1 = 8'h00;
    set2 = 8'h00;
    set0[`PIFB_BIT_TMR0] = I_TMR0_OVERFLOW;
    set0[`PIFB_BIT_EXT] = ext_edge;
    set1[`PIFB_BIT_T1G] = I_TIMER_ONE_GATE_INACTIVE;
    set1[`PIFB_BIT_T1] = I_TIMER_ONE_EVENT;
    set1[`PIFB_BIT_OSF] = I_OSCILLATOR_FAIL;
    set1[`PIFB_BIT_CSW] = I_CLOCK_SWITCH_EVENT;
    set1[`PIFB_BIT_SCAN] = I_MEMORY_SCANNER_EVENT;
    set1[`PIFB_BIT_CRC] = I_CHECKSUM_EVENT;
    set1[`PIFB_BIT_NVM] = I_NONVOLATILE_DONE;
    set2[`PIFB_BIT_CCP2] = ccp2_hit;
    set2[`PIFB_BIT_CCP1] = ccp1_hit;
    set2[`PIFB_BIT_TMR2] = I_TIMER_TWO_EVENT;
    // read view of request zero with the live summary bit
    req0_view = req0_q;
    req0_view[`PIFB_BIT_IOC] = pin_change_summary_flag;
  end

  // next values of flags and enables
  always_comb begin
    // write loads, hardware set ORed last so it wins
    req0_d = (((wr_take && hit_req0 && lane0) ? wbyte : req0_q) | set0) & `PIFB_MASK_REQ0;
    req1_d = (((wr_take && hit_req1 && lane0) ? wbyte : req1_q) | set1) & `PIFB_MASK_REQ1;
    req2_d = (((wr_take && hit_req2 && lane0) ? wbyte : req2_q) | set2) & `PIFB_MASK_REQ2;
    // enable six keeps only the converter bits
    en6_d = ((wr_take && hit_en6 && lane0) ? wbyte : en6_q) & `PIFB_MASK_EN6;
    en7_d = ((wr_take && hit_en7 && lane0) ? wbyte : en7_q) & `PIFB_MASK_EN7;
    ctrl_d = ((wr_take && hit_ctrl && lane0) ? wbyte : ctrl_q) & `PIFB_MASK_CTRL;
    psel_d = ((wr_take && hit_psel && lane0) ? wbyte : psel_q) & `PIFB_MASK_PSEL;
  end

  // flag and enable registers
  always_ff @(posedge I_REF_CLK) begin
    // all implemented bits reset to zero
    if (!I_NRST) begin
      req0_q <= `PIFB_RESET_VAL;
      req1_q <= `PIFB_RESET_VAL;
      req2_q <= `PIFB_RESET_VAL;
      en6_q <= `PIFB_RESET_VAL;
      en7_q <= `PIFB_RESET_VAL;
      ctrl_q <= `PIFB_RESET_VAL;
      psel_q <= `PIFB_RESET_VAL;
    end else begin
      req0_q <= req0_d;
      req1_q <= req1_d;
      req2_q <= req2_d;
      en6_q <= en6_d;
      en7_q <= en7_d;
      ctrl_q <= ctrl_d;
      psel_q <= psel_d;
    end
  end

  // interrupt request combine
  always_comb begin
    // group zero needs only the global enable
    // stale flags fire at once when enabled
    irq_d = ctrl_q[`PIFB_BIT_GLOBAL] & (
      (|(req0_view & I_ENABLE_BITS_ZERO & `PIFB_MASK_REQ0 |
         {2'h0, pin_change_summary_flag, 5'h00} & I_ENABLE_BITS_ZERO)) |
      (ctrl_q[`PIFB_BIT_PERIPH] & (
        (|(req1_q & I_ENABLE_BITS_ONE)) |
        (|(req2_q & I_ENABLE_BITS_TWO)) |
        (I_CONVERTER_REQ[1] & en6_q[`PIFB_BIT_ADT]) |
        (I_CONVERTER_REQ[0] & en6_q[`PIFB_BIT_AD]) |
        (|(I_LOGIC_BLOCK_REQ & en7_q[3:0])))));
  end

  // interrupt output register
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // outputs from registers
  assign O_IRQ = irq_q;
  assign O_ENABLE_BITS_SIX = en6_q[1:0];
  assign O_ENABLE_BITS_SEVEN = en7_q[3:0];

endmodule : pifb_top
`default_nettype wire

// ---- verification/pifb_top_sva.sv ----
// port assertions of the interrupt flag bank
`timescale 1ns/1ns
`default_nettype none
module pifb_top_sva (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [9:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic I_TMR0_OVERFLOW,
  input wire logic [2:0] I_PER_PORT_PIN_CHANGE_FLAGS,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic [1:0] O_AVS_RESPONSE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [1:0] O_ENABLE_BITS_SIX,
  input wire logic [3:0] O_ENABLE_BITS_SEVEN,
  input wire logic O_IRQ
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  // a read is taken at this edge
  logic rd_done;
  // address hits a register of the bank
  logic mapped;
  assign rd_done = I_AVS_READ && !O_AVS_WAITREQUEST;
  assign mapped = (I_AVS_ADDRESS[1:0] == 2'h0) && (I_AVS_ADDRESS[9:2] inside
    {8'h8c, 8'h8d, 8'h8e, 8'h9c, 8'h9d, 8'h0b, 8'h9e});
  a_wait_first: assert property ((I_AVS_READ || I_AVS_WRITE) && !$past(I_AVS_READ || I_AVS_WRITE)
    |-> O_AVS_WAITREQUEST) else $error("no wait cycle on new request");
  a_wait_once: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
    |=> !O_AVS_WAITREQUEST) else $error("more than one wait cycle");
  a_rdata_upper: assert property (rd_done |-> O_AVS_READDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_resp_bad: assert property (rd_done && !mapped |-> O_AVS_RESPONSE == 2'h3
    && O_AVS_READDATA == 32'h0) else $error("unmapped read not refused");
  a_resp_okay: assert property (rd_done && mapped |-> O_AVS_RESPONSE == 2'h0)
    else $error("mapped read refused");
  a_en7_view: assert property (rd_done && I_AVS_ADDRESS == 10'h274
    |-> O_AVS_READDATA[7:0] == {4'h0, O_ENABLE_BITS_SEVEN}) else $error("enable seven mismatch");
  a_en6_view: assert property (rd_done && I_AVS_ADDRESS == 10'h270
    |-> O_AVS_READDATA[7:0] == {6'h0, O_ENABLE_BITS_SIX}) else $error("enable six mismatch");
  a_pin_live: assert property (rd_done && I_AVS_ADDRESS == 10'h230
    |-> O_AVS_READDATA[4] == |$past(I_PER_PORT_PIN_CHANGE_FLAGS)) else $error("summary flag wrong");
  a_tmr0_sets: assert property (rd_done && I_AVS_ADDRESS == 10'h230
    && $past(I_TMR0_OVERFLOW, 2) |-> O_AVS_READDATA[5]) else $error("overflow flag missed");
  a_reset_quiet: assert property (!$past(I_NRST) |-> !O_IRQ && O_AVS_RESPONSE == 2'h0)
    else $error("outputs busy after reset");
  a_reset_enables: assert property (!$past(I_NRST)
    |-> O_ENABLE_BITS_SIX == 2'h0 && O_ENABLE_BITS_SEVEN == 4'h0) else $error("enables not reset");
endmodule : pifb_top_sva
bind pifb_top pifb_top_sva pifb_top_sva_inst (
  .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_TMR0_OVERFLOW(I_TMR0_OVERFLOW),
  .I_PER_PORT_PIN_CHANGE_FLAGS(I_PER_PORT_PIN_CHANGE_FLAGS), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_RESPONSE(O_AVS_RESPONSE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_ENABLE_BITS_SIX(O_ENABLE_BITS_SIX), .O_ENABLE_BITS_SEVEN(O_ENABLE_BITS_SEVEN), .O_IRQ(O_IRQ));
`default_nettype wire

// ---- verification/pifb_periph_model.sv ----
// model of the peripherals that raise interrupt events
`timescale 1ns/1ns
`default_nettype none
module pifb_periph_model (
  input wire logic i_clk,
  input wire logic [3:0] i_sel,
  input wire logic i_go,
  output logic [11:0] o_ev
);
  // one-cycle pulse on the chosen source, quiet otherwise
  // mode event pulses
  always_ff @(posedge i_clk) begin
    o_ev <= i_go ? (12'h1 << i_sel) : 12'h0;
  end
endmodule : pifb_periph_model
`default_nettype wire

// ---- verification/pifb_top_test.sv ----
// self-checking bench of the interrupt flag bank
`timescale 1ns/1ns
`default_nettype none
module pifb_top_test;
  logic clk, nrst, rd, wr, go, waitreq, irq;
  logic [9:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] resp, rsp, en6, mode, mode2, cvreq;
  logic [3:0] en7, sel, lbreq, be;
  logic [2:0] pcf;
  logic [7:0] pins, enz, eno, ent;
  logic [11:0] ev;
  int miscompares, compares, cyc;
  // flag table: register index and bit of event sources 0 to 8
  logic [7:0] ridx [9] = '{8'h8c, 8'h8d, 8'h8d, 8'h8d, 8'h8d, 8'h8d, 8'h8d, 8'h8d, 8'h8e};
  logic [2:0] rbit [9] = '{3'h5, 3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h2};
  pifb_top pifb_top_inst (.I_REF_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_RESPONSE(resp), .O_AVS_WAITREQUEST(waitreq),
    .I_TMR0_OVERFLOW(ev[0]), .I_PER_PORT_PIN_CHANGE_FLAGS(pcf), .I_EXT_IRQ_PINS(pins),
    .I_TIMER_ONE_GATE_INACTIVE(ev[1]), .I_TIMER_ONE_EVENT(ev[2]), .I_OSCILLATOR_FAIL(ev[3]),
    .I_CLOCK_SWITCH_EVENT(ev[4]), .I_MEMORY_SCANNER_EVENT(ev[5]), .I_CHECKSUM_EVENT(ev[6]),
    .I_NONVOLATILE_DONE(ev[7]), .I_CAPCOMP_ONE_MODE(mode), .I_CAPCOMP_ONE_EVENTS(ev[11:9]),
    .I_CAPCOMP_TWO_MODE(mode2), .I_CAPCOMP_TWO_EVENTS(ev[11:9]), .I_TIMER_TWO_EVENT(ev[8]),
    .I_ENABLE_BITS_ZERO(enz), .I_ENABLE_BITS_ONE(eno), .I_ENABLE_BITS_TWO(ent),
    .I_CONVERTER_REQ(cvreq), .I_LOGIC_BLOCK_REQ(lbreq), .O_ENABLE_BITS_SIX(en6),
    .O_ENABLE_BITS_SEVEN(en7), .O_IRQ(irq));
  pifb_periph_model pifb_periph_model_inst (.i_clk(clk), .i_sel(sel), .i_go(go), .o_ev(ev));
  // compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    addr <= {idx, 2'h0};
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    got = rdata;
    rsp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wrr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wrr
  // read a register and expect an okay answer
  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 8'h00);
    chk(got, e);
    chk(rsp, 32'h0);
  endtask : rdc
  // pulse one event source through the peripheral model
  task automatic fire(input logic [3:0] s);
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask : fire
  // let the registered request settle, then look between edges
  task automatic irqc(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, e);
    @(posedge clk);
  endtask : irqc
  task automatic t_reset();
    for (int i = 0; i < 5; i++) rdc((i < 3) ? 8'(8'h8c + i) : 8'(8'h99 + i), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_enables();
    wrr(8'h9d, 8'hff);
    rdc(8'h9d, 32'h0f);
    chk(en7, 32'hf);
    wrr(8'h9c, 8'hff);
    rdc(8'h9c, 32'h03);
    chk(en6, 32'h3);
    $display("test enables done");
  endtask : t_enables
  task automatic t_events();
    for (int i = 0; i < 9; i++) begin
      fire(i[3:0]);
      rdc(ridx[i], 32'h1 << rbit[i]);
      wrr(ridx[i], 8'h00);
      rdc(ridx[i], 32'h0);
    end
    fork
      wrr(8'h8d, 8'h00);
      fire(4'h2);
    join
    rdc(8'h8d, 32'h40);
    wrr(8'h8d, 8'h00);
    $display("test events done");
  endtask : t_events
  task automatic t_capcomp();
    for (int m = 1; m < 4; m++) begin
      mode <= m[1:0];
      mode2 <= m[1:0];
      fire(4'(8 + m));
      rdc(8'h8e, 32'h60);
      wrr(8'h8e, 8'h00);
      fire(4'(9 + (m % 3)));
      rdc(8'h8e, 32'h0);
    end
    // unit two off, unit one capturing: only bit 5 may rise
    mode <= 2'h1;
    mode2 <= 2'h0;
    fire(4'h9);
    rdc(8'h8e, 32'h20);
    wrr(8'h8e, 8'h00);
    // both units off: no flag at all
    mode <= 2'h0;
    fire(4'h9);
    rdc(8'h8e, 32'h0);
    $display("test capcomp done");
  endtask : t_capcomp
  task automatic t_pinchg();
    pcf <= 3'h4;
    @(posedge clk);
    rdc(8'h8c, 32'h10);
    wrr(8'h8c, 8'h00);
    rdc(8'h8c, 32'h10);
    pcf <= 3'h0;
    @(posedge clk);
    rdc(8'h8c, 32'h0);
    $display("test pin change done");
  endtask : t_pinchg
  task automatic t_ext();
    wrr(8'h9e, 8'h03);
    pins <= 8'h04;
    repeat (4) @(posedge clk);
    rdc(8'h8c, 32'h0);
    pins <= 8'h0c;
    repeat (4) @(posedge clk);
    rdc(8'h8c, 32'h1);
    pins <= 8'h00;
    wrr(8'h8c, 8'h00);
    $display("test external done");
  endtask : t_ext
  task automatic t_irq();
    eno <= 8'h40;
    enz <= 8'h20;
    wrr(8'h0b, 8'h03);
    fire(4'h2);
    irqc(1'b1);
    wrr(8'h0b, 8'h02);
    irqc(1'b0);
    fire(4'h0);
    irqc(1'b1);
    wrr(8'h8c, 8'h00);
    wrr(8'h8d, 8'h00);
    wrr(8'h0b, 8'h03);
    lbreq <= 4'h8;
    irqc(1'b1);
    wrr(8'h9d, 8'h07);
    irqc(1'b0);
    lbreq <= 4'h0;
    cvreq <= 2'h2;
    irqc(1'b1);
    wrr(8'h9c, 8'h01);
    irqc(1'b0);
    cvreq <= 2'h1;
    irqc(1'b1);
    // request two reaches the line through its outside enables
    cvreq <= 2'h0;
    ent <= 8'h04;
    irqc(1'b0);
    fire(4'h8);
    irqc(1'b1);
    $display("test irq done");
  endtask : t_irq
  task automatic t_unmapped();
    bus(1'b0, 8'h50, 8'h00);
    chk(got, 32'h0);
    chk(rsp, 32'h3);
    // a write with lane 0 off must leave the register alone
    be <= 4'h0;
    wrr(8'h9d, 8'h00);
    be <= 4'h1;
    rdc(8'h9d, 32'h07);
    $display("test unmapped done");
  endtask : t_unmapped
  // verdict and end of run
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // 10 mhz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {nrst, rd, wr, go, sel, addr, wdata, mode, mode2, pcf, pins, cvreq, lbreq} = '0;
    {enz, eno, ent} = '0;
    be = 4'h1;
    miscompares = 0;
    compares = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_events();
    t_capcomp();
    t_pinchg();
    t_ext();
    t_enables();
    t_irq();
    t_unmapped();
    // second reset with written state: request and enable registers must come back to zero
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    end_sim();
  end
endmodule : pifb_top_test
`default_nettype wire
